// [rtl/pwm_edge_timing.sv]
// Edge placement for the two PWM outputs with byte register access
`default_nettype none
`include "pwm_edge_regs.svh"

module pwm_edge_timing
  import pwm_edge_pkg::*;
#(
  parameter int TIME_W = 12
) (
  // Clock and reset
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  // Register port
  input wire reg_req_t reg_req_in,
  output logic [7:0] reg_rdata_out,
  // Loop and period counter
  input wire logic [TIME_W-1:0] mod_value_in,
  input wire period_t period_in,
  // Power stage pins
  output logic pwm_output_first_out,
  output logic pwm_output_second_out
);

  // ------------------------------------------------------------
  // Edge arithmetic
  // ------------------------------------------------------------
  // Saturates at both ends so a large modulation never wraps an edge
  // around to the far side of the period.
  function automatic logic [TIME_W-1:0] edge_eff(input logic [TIME_W-1:0] base,
                                                 input edge_setting_t set,
                                                 input logic [TIME_W-1:0] mod);
    logic [TIME_W:0] sum;
    sum = {1'b0, base} + {1'b0, mod};
    if (!set.mod_en) begin
      edge_eff = base;
    end else if (set.sign_neg) begin
      edge_eff = sum[TIME_W] ? {TIME_W{1'b1}} : sum[TIME_W-1:0];
    end else begin
      edge_eff = (mod > base) ? '0 : base - mod;
    end
  endfunction

  // Output is high from rise up to fall; a rise after the fall wraps over period end.
  function automatic logic in_window(input logic [TIME_W-1:0] cnt,
                                     input logic [TIME_W-1:0] rise,
                                     input logic [TIME_W-1:0] fall);
    if (rise <= fall) begin
      in_window = (cnt >= rise) && (cnt < fall);
    end else begin
      in_window = (cnt >= rise) || (cnt < fall);
    end
  endfunction

  // ------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------
  // Index 0: first rise, 1: first fall, 2: second rise, 3: second fall.
  logic [7:0] time_high_reg [4];
  edge_setting_t setting_reg [4];
  logic [7:0] reg_rdata_reg;
  logic [TIME_W-1:0] mod_reg;
  logic first_reg;
  logic second_reg;

  wire logic [7:0] addr_rel = reg_req_in.addr - `OFS_OUT_A_RISE_TIME_HIGH;
  wire logic addr_hit = (reg_req_in.addr >= `OFS_OUT_A_RISE_TIME_HIGH) &&
                        (reg_req_in.addr <= `OFS_OUT_B_FALL_SETTING);
  wire logic [1:0] addr_edge = addr_rel[2:1];
  wire logic addr_is_setting = addr_rel[0];
  wire logic wr_time = reg_req_in.wr && addr_hit && !addr_is_setting;
  wire logic wr_set = reg_req_in.wr && addr_hit && addr_is_setting;
  wire logic [7:0] rd_value = !addr_hit ? 8'h00 :
                              addr_is_setting ? setting_reg[addr_edge] :
                              time_high_reg[addr_edge];

  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      for (int i = 0; i < 4; i++) begin
        time_high_reg[i] <= `RST_TIME_HIGH;
        setting_reg[i] <= `RST_SETTING;
      end
    end else if (wr_time) begin
      time_high_reg[addr_edge] <= reg_req_in.wdata;
    end else if (wr_set) begin
      // Bits 1:0 are stored as written; software keeps them zero
      setting_reg[addr_edge] <= reg_req_in.wdata;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      reg_rdata_reg <= 8'h00;
    end else if (reg_req_in.rd) begin
      reg_rdata_reg <= rd_value;
    end
  end

  // ------------------------------------------------------------
  // Edge times
  // ------------------------------------------------------------
  wire logic [TIME_W-1:0] first_rise_time =
    {time_high_reg[0], setting_reg[0].time_low};
  wire logic [TIME_W-1:0] first_fall_time =
    {time_high_reg[1], setting_reg[1].time_low};
  wire logic [TIME_W-1:0] second_rise_time =
    {time_high_reg[2], setting_reg[2].time_low};
  wire logic [TIME_W-1:0] second_fall_time =
    {time_high_reg[3], setting_reg[3].time_low};

  wire logic [TIME_W-1:0] first_rise_eff = edge_eff(first_rise_time, setting_reg[0], mod_reg);
  wire logic [TIME_W-1:0] first_fall_eff = edge_eff(first_fall_time, setting_reg[1], mod_reg);
  wire logic [TIME_W-1:0] second_rise_eff = edge_eff(second_rise_time, setting_reg[2], mod_reg);
  wire logic [TIME_W-1:0] second_fall_eff = edge_eff(second_fall_time, setting_reg[3], mod_reg);

  // Count is in 5 ns steps, so one unit of edge time is one step of the count.
  wire logic first_next = in_window(period_in.count, first_rise_eff, first_fall_eff);
  wire logic second_next = in_window(period_in.count, second_rise_eff, second_fall_eff);

  // ------------------------------------------------------------
  // Modulation and outputs
  // ------------------------------------------------------------
  // Modulation only changes at a period start, so an edge never jumps twice in one period.
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      mod_reg <= '0;
    end else if (period_in.start) begin
      mod_reg <= mod_value_in;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      first_reg <= 1'b0;
      second_reg <= 1'b0;
    end else begin
      first_reg <= first_next;
      second_reg <= second_next;
    end
  end

  assign reg_rdata_out = reg_rdata_reg;
  assign pwm_output_first_out = first_reg;
  assign pwm_output_second_out = second_reg;

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  property p_rise_a_high;
    @(posedge sys_clk_in) disable iff (!rst_n_in)
      reg_req_in.wr && reg_req_in.addr == `OFS_OUT_A_RISE_TIME_HIGH
      |=> first_rise_time[11:4] == $past(reg_req_in.wdata);
  endproperty
  a_rise_a_high: assert property (p_rise_a_high)
    else $error("first rise upper bits not taken from its timing byte");

  property p_rise_a_low;
    @(posedge sys_clk_in) disable iff (!rst_n_in)
      reg_req_in.wr && reg_req_in.addr == `OFS_OUT_A_RISE_SETTING
      |=> first_rise_time[3:0] == $past(reg_req_in.wdata[7:4]);
  endproperty
  a_rise_a_low: assert property (p_rise_a_low)
    else $error("first rise low nibble not taken from setting bits 7:4");

  property p_fall_a;
    @(posedge sys_clk_in) disable iff (!rst_n_in)
      reg_req_in.wr && reg_req_in.addr == `OFS_OUT_A_FALL_TIME_HIGH
      |=> first_fall_time[11:4] == $past(reg_req_in.wdata);
  endproperty
  a_fall_a: assert property (p_fall_a)
    else $error("first fall upper bits wrong");

  property p_rise_b;
    @(posedge sys_clk_in) disable iff (!rst_n_in)
      reg_req_in.wr && reg_req_in.addr == `OFS_OUT_B_RISE_SETTING
      |=> second_rise_time[3:0] == $past(reg_req_in.wdata[7:4]);
  endproperty
  a_rise_b: assert property (p_rise_b)
    else $error("second rise low nibble wrong");

  property p_fall_b;
    @(posedge sys_clk_in) disable iff (!rst_n_in)
      reg_req_in.wr && reg_req_in.addr == `OFS_OUT_B_FALL_TIME_HIGH
      |=> second_fall_time[11:4] == $past(reg_req_in.wdata);
  endproperty
  a_fall_b: assert property (p_fall_b)
    else $error("second fall upper bits wrong");

  property p_hold;
    @(posedge sys_clk_in) disable iff (!rst_n_in)
      !setting_reg[0].mod_en && $stable(first_rise_time) && $changed(mod_reg)
      |-> first_rise_eff == first_rise_time;
  endproperty
  a_hold: assert property (p_hold)
    else $error("unmodulated edge moved with modulation");

  property p_neg;
    @(posedge sys_clk_in) disable iff (!rst_n_in)
      setting_reg[1].mod_en && setting_reg[1].sign_neg &&
      ({1'b0, first_fall_time} + {1'b0, mod_reg}) < 13'h1000
      |-> first_fall_eff == first_fall_time + mod_reg;
  endproperty
  a_neg: assert property (p_neg)
    else $error("negative sign edge not moved later by modulation");

  property p_pos;
    @(posedge sys_clk_in) disable iff (!rst_n_in)
      setting_reg[2].mod_en && !setting_reg[2].sign_neg && mod_reg <= second_rise_time
      |-> second_rise_eff == second_rise_time - mod_reg;
  endproperty
  a_pos: assert property (p_pos)
    else $error("positive sign edge not moved earlier by modulation");

  property p_rise_out;
    @(posedge sys_clk_in) disable iff (!rst_n_in)
      $rose(pwm_output_first_out) |-> $past(period_in.count) >= $past(first_rise_eff) ||
                                      $past(period_in.count) < $past(first_fall_eff);
  endproperty
  a_rise_out: assert property (p_rise_out)
    else $error("first output rose outside its window");

  property p_fall_out;
    @(posedge sys_clk_in) disable iff (!rst_n_in)
      second_rise_eff < second_fall_eff && period_in.count >= second_fall_eff
      |=> !pwm_output_second_out;
  endproperty
  a_fall_out: assert property (p_fall_out)
    else $error("second output high past its falling edge");

  property p_read_a_high;
    @(posedge sys_clk_in) disable iff (!rst_n_in)
      reg_req_in.rd && reg_req_in.addr == `OFS_OUT_A_RISE_TIME_HIGH
      |=> reg_rdata_out == $past(first_rise_time[11:4]);
  endproperty
  a_read_a_high: assert property (p_read_a_high)
    else $error("first rise timing byte not read back");

  // Writes outside the block's byte range must not touch any edge
  property p_ignore_far;
    @(posedge sys_clk_in) disable iff (!rst_n_in)
      reg_req_in.wr && !addr_hit
      |=> $stable(first_rise_time) && $stable(first_fall_time) &&
          $stable(second_rise_time) && $stable(second_fall_time);
  endproperty
  a_ignore_far: assert property (p_ignore_far)
    else $error("edge time changed by a write outside the block");

  property p_hold_b;
    @(posedge sys_clk_in) disable iff (!rst_n_in)
      !setting_reg[3].mod_en |-> second_fall_eff == second_fall_time;
  endproperty
  a_hold_b: assert property (p_hold_b)
    else $error("unmodulated second fall edge moved");

  // Late edges clamp at the period end instead of wrapping
  property p_neg_sat;
    @(posedge sys_clk_in) disable iff (!rst_n_in)
      setting_reg[0].mod_en && setting_reg[0].sign_neg &&
      ({1'b0, first_rise_time} + {1'b0, mod_reg}) >= 13'h1000
      |-> first_rise_eff == 12'hfff;
  endproperty
  a_neg_sat: assert property (p_neg_sat)
    else $error("negative sign edge not clamped at the period end");

  property p_pos_floor;
    @(posedge sys_clk_in) disable iff (!rst_n_in)
      setting_reg[1].mod_en && !setting_reg[1].sign_neg && mod_reg > first_fall_time
      |-> first_fall_eff == 12'h000;
  endproperty
  a_pos_floor: assert property (p_pos_floor)
    else $error("positive sign edge not clamped at the period start");

  property p_rise_in;
    @(posedge sys_clk_in) disable iff (!rst_n_in)
      second_rise_eff < second_fall_eff && period_in.count >= second_rise_eff &&
      period_in.count < second_fall_eff
      |=> pwm_output_second_out;
  endproperty
  a_rise_in: assert property (p_rise_in)
    else $error("second output low inside its window");

  property p_equal_low;
    @(posedge sys_clk_in) disable iff (!rst_n_in)
      first_rise_eff == first_fall_eff |=> !pwm_output_first_out;
  endproperty
  a_equal_low: assert property (p_equal_low)
    else $error("first output high with coinciding edges");

  property p_mod_latch;
    @(posedge sys_clk_in) disable iff (!rst_n_in)
      !period_in.start |=> $stable(mod_reg);
  endproperty
  a_mod_latch: assert property (p_mod_latch)
    else $error("modulation amount changed inside a period");

  // ------------------------------------------------------------
  // Scenario covers
  // ------------------------------------------------------------
  c_first_pulse: cover property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    $rose(pwm_output_first_out) ##[1:1000] $fell(pwm_output_first_out));
  c_second_pulse: cover property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    $rose(pwm_output_second_out));
  c_modulated: cover property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    setting_reg[0].mod_en && mod_reg != '0 && first_rise_eff != first_rise_time);
  c_read: cover property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    reg_req_in.rd && addr_hit);
  c_wrap: cover property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    second_rise_eff > second_fall_eff && pwm_output_second_out);

endmodule
`default_nettype wire

// [include/pwm_edge_regs.svh]
// Register offsets, field positions, reset values and timing for the edge timing block
// Overview of operation
// - Each edge time is 12 bits: a full timing byte on top and setting bits 7:4 below it.
// - One unit of edge time places the edge 5 ns later within the switching period.
// - With setting bit 3 clear, the edge stays at its programmed time whatever the modulation.
// - With setting bit 2 set, a growing modulation moves the edge later.
// - With setting bit 2 clear, a growing modulation moves the edge earlier.
// - The timing byte supplies all of its bits 7:0 as the upper part of the edge time.
// - The first output's falling edge uses byte out_a_fall_time_high and the top nibble of byte out_a_fall_setting.
// - The second output's rising edge uses out_b_rise_time_high/out_b_rise_setting and its falling edge out_b_fall_time_high/out_b_fall_setting.
// - The first output's rising edge uses byte 0x41 and the top nibble of byte out_a_rise_setting.
`ifndef PWM_EDGE_REGS_SVH
`define PWM_EDGE_REGS_SVH

`define OFS_OUT_A_RISE_TIME_HIGH 8'h41
`define OFS_OUT_A_RISE_SETTING 8'h42
`define OFS_OUT_A_FALL_TIME_HIGH 8'h43
`define OFS_OUT_A_FALL_SETTING 8'h44
`define OFS_OUT_B_RISE_TIME_HIGH 8'h45
`define OFS_OUT_B_RISE_SETTING 8'h46
`define OFS_OUT_B_FALL_TIME_HIGH 8'h47
`define OFS_OUT_B_FALL_SETTING 8'h48

`define SET_TIME_LOW_MSB 7
`define SET_TIME_LOW_LSB 4
`define SET_MOD_EN_BIT 3
`define SET_SIGN_NEG_BIT 2

`define RST_TIME_HIGH 8'h00
`define RST_SETTING 8'h00

`define EDGE_STEP_NS 5
`define CLK_PERIOD_NS 25
`define STEPS_PER_CLK (`CLK_PERIOD_NS / `EDGE_STEP_NS)

`endif

// [include/pwm_edge_pkg.sv]
// Types shared by the edge timing block
`default_nettype none
package pwm_edge_pkg;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;

  typedef struct packed {
    logic [3:0] time_low;
    logic mod_en;
    logic sign_neg;
    logic [1:0] reserved;
  } edge_setting_t;

  typedef struct packed {
    logic [11:0] count;
    logic start;
  } period_t;

endpackage
`default_nettype wire

// [bench/pwm_power_stage_model.sv]
// Power stage model: counts gate-on cycles of both switch drivers
`default_nettype none
module pwm_power_stage_model (
  // Clock and window clear
  input wire logic clk_in,
  input wire logic clr_in,
  // Gate drive pins
  input wire logic gate_a_in,
  input wire logic gate_b_in,
  // On-time totals
  output logic [15:0] on_a_out,
  output logic [15:0] on_b_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // Drivers act on the level only; an unknown gate level poisons the total
  always @(posedge clk_in) begin
    on_a_out <= clr_in ? 16'h0000 : on_a_out + 16'(gate_a_in);
    on_b_out <= clr_in ? 16'h0000 : on_b_out + 16'(gate_b_in);
  end
endmodule
`default_nettype wire

// [bench/test_pwm_edge_timing.sv]
// Self-checking bench for the two-output edge timing block
`default_nettype none
`include "pwm_edge_regs.svh"
module test_pwm_edge_timing
  import pwm_edge_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] BASE = `OFS_OUT_A_RISE_TIME_HIGH;
  logic sys_clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic clr = 1'b1;
  reg_req_t req = '0;
  period_t per = '0;
  logic [11:0] mod_value = 12'h000;
  logic [7:0] rdata;
  logic out_a, out_b;
  logic [15:0] on_a, on_b;
  logic [7:0] regs [8];
  logic [11:0] pc;
  int n_errors = 0, num_checks = 0, cycles = 0, exp_a, exp_b;
  int seed = 32'hc497dedc;

  always #12.5 sys_clk_in = ~sys_clk_in;

  pwm_edge_timing i_dut (.sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in), .reg_req_in(req),
    .reg_rdata_out(rdata), .mod_value_in(mod_value), .period_in(per),
    .pwm_output_first_out(out_a), .pwm_output_second_out(out_b));
  pwm_power_stage_model i_stage (.clk_in(sys_clk_in), .clr_in(clr), .gate_a_in(out_a),
    .gate_b_in(out_b), .on_a_out(on_a), .on_b_out(on_b));

  // ----------------------------------------
  // Checking and expectations
  // ----------------------------------------
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic end_sim();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // Edge index 0..3: first rise, first fall, second rise, second fall
  function automatic logic [11:0] eff(input int i);
    logic [12:0] t;
    t = {1'b0, regs[2*i], regs[2*i+1][7:4]};
    if (!regs[2*i+1][3]) return t[11:0];
    if (regs[2*i+1][2]) begin
      t = t + 13'(mod_value);
      return t[12] ? 12'hfff : t[11:0];
    end
    return (t[11:0] > mod_value) ? t[11:0] - mod_value : 12'h000;
  endfunction

  function automatic logic lvl(input logic [11:0] r, input logic [11:0] f);
    return (r <= f) ? (pc >= r && pc < f) : (pc >= r || pc < f);
  endfunction

  // ----------------------------------------
  // Drivers
  // ----------------------------------------
  task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge sys_clk_in);
    req = '{a, d, 1'b1, 1'b0};
  endtask

  task automatic reg_rd(input logic [7:0] a, input logic [7:0] e);
    @(negedge sys_clk_in);
    req = '{a, 8'h00, 1'b0, 1'b1};
    @(negedge sys_clk_in);
    req = '0;
    check(rdata, e);
  endtask

  task automatic run(input logic chk);
    for (int k = 0; k < 820; k++) begin
      @(negedge sys_clk_in);
      clr = chk && k == 0;
      if (chk && k > 0) begin
        check(out_a, lvl(eff(0), eff(1)));
        check(out_b, lvl(eff(2), eff(3)));
        exp_a += lvl(eff(0), eff(1));
        exp_b += lvl(eff(2), eff(3));
      end
      per = '{12'(k * 5), k == 0};
      pc = per.count;
    end
  endtask

  task automatic scen();
    for (int i = 0; i < 8; i++) reg_wr(BASE + 8'(i), regs[i]);
    @(negedge sys_clk_in);
    req = '0;
    exp_a = 0;
    exp_b = 0;
    run(1'b0);
    run(1'b1);
    @(negedge sys_clk_in);
    check(on_a, 16'(exp_a));
    check(on_b, 16'(exp_b));
    for (int i = 0; i < 8; i++) reg_rd(BASE + 8'(i), regs[i]);
  endtask

  always @(posedge sys_clk_in) begin
    cycles++;
    if (cycles == 40000) begin
      n_errors++;
      end_sim();
    end
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (8) @(negedge sys_clk_in);
    rst_n_in = 1'b1;
    for (int i = 0; i < 8; i++) reg_rd(BASE + 8'(i), 8'h00);
    check(out_a, 1'b0);
    check(out_b, 1'b0);
    reg_wr(8'h49, 8'h5a);
    reg_rd(8'h49, 8'h00);
    reg_rd(8'h40, 8'h00);
    // Saturation at both ends of the count
    regs = '{8'h0f, 8'h0c, 8'h80, 8'h08, 8'hff, 8'hf8, 8'h01, 8'h08};
    mod_value = 12'hf80;
    scen();
    // Disabled modulation ignores a full-scale amount
    regs = '{8'h20, 8'h04, 8'h60, 8'h00, 8'h70, 8'h00, 8'h10, 8'h04};
    mod_value = 12'hfff;
    scen();
    for (int n = 0; n < 14; n++) begin
      foreach (regs[i]) regs[i] = 8'($random(seed));
      for (int i = 1; i < 8; i += 2) regs[i][1:0] = 2'b00;
      mod_value = 12'($random(seed));
      scen();
    end
    end_sim();
  end
endmodule
`default_nettype wire
